// File: hw/dtp_probe_latch.sv
// Purpose: Per-axis dual touch probe position latch with object access.
// Assumes: The fieldbus stack decodes the axis sub-index and presents
//          a single-cycle object read/write strobe for this axis.
// Notes:   Reserved control bits are stored but never reach a channel.
// Notes on behaviour
// - Two independent probe channels latch positions.
// - Control low byte probe one, high two.
// - Enable bit gates each channel's capture.
// - Mode bit: first trigger only or every.
// - Source bit: external latch or internal signal.
// - Rising-edge capture enable bit per channel.
// - Falling-edge capture enable bit per channel.
// - Control word resets zero, any value writable.
// - External trigger latches feedback or command position.
// - Internal selector: zero marker or timing pulse.
// - Timing pulse once per 7.2 degrees.
// - Each external latch input serves one channel.
// - Both internal signals usable by both channels.
// - Four read-only signed 32-bit capture registers.
// - Control received, status/positions transmitted as process data.
// - Status: enabled, rising flag, falling flag per channel.
// - Zero marker latches feedback, timing latches command.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_probe_latch
  import dtp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  // Receive process data: control word, applied when the strobe is high.
  input wire logic receive_process_data_valid,
  input wire logic [15:0] receive_process_data_control,
  // Transmit process data, refreshed every cycle.
  output logic [15:0] transmit_process_data_status,
  output dtp_pos_t transmit_process_data_p1_rise,
  output dtp_pos_t transmit_process_data_p1_fall,
  output dtp_pos_t transmit_process_data_p2_rise,
  output dtp_pos_t transmit_process_data_p2_fall,
  // Mailbox object access for every object of this axis.
  input wire logic obj_req,
  input wire logic obj_write,
  input wire logic [15:0] obj_index,
  input wire logic [31:0] obj_wdata,
  output logic obj_ack,
  output logic obj_err,
  output logic [31:0] obj_rdata,
  // Trigger inputs.
  input wire logic first_external_latch_input,
  input wire logic second_external_latch_input,
  input wire logic zero_marker_signal,
  input wire logic rotation_timing_pulse,
  // Positions of this axis.
  input wire dtp_pos_t feedback_pos,
  input wire dtp_pos_t command_pos
);

  logic [15:0] probe_control_word;
  dtp_half_t probe1_capture_quantity_select;
  dtp_half_t probe2_capture_quantity_select;
  dtp_half_t probe1_internal_trigger_select;
  dtp_half_t probe2_internal_trigger_select;
  dtp_half_t sts1;
  dtp_half_t sts2;
  dtp_pos_t p1_rise;
  dtp_pos_t p1_fall;
  dtp_pos_t p2_rise;
  dtp_pos_t p2_fall;
  logic [15:0] probe_status_word;
  logic wr;
  logic hit;
  logic [31:0] next_rdata;

  // Reserved control bits are masked off before they reach a channel.
  function automatic dtp_half_t dtp_ctl_half(input logic [7:0] raw);
    dtp_ctl_half = raw & 8'h37;
  endfunction

  // Objects that refuse writes: the status word and the four captures.
  function automatic logic dtp_read_only(input logic [15:0] idx);
    dtp_read_only = idx == `DTP_IDX_STATUS ||
      idx == `DTP_IDX_P1_RISE_POS || idx == `DTP_IDX_P1_FALL_POS ||
      idx == `DTP_IDX_P2_RISE_POS || idx == `DTP_IDX_P2_FALL_POS;
  endfunction

  // -------------------------------------------------------------
  // Writable objects
  // -------------------------------------------------------------
  assign wr = obj_req && obj_write;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      probe_control_word <= `DTP_CONTROL_RESET;
    else if (receive_process_data_valid)
      probe_control_word <= receive_process_data_control;
    else if (wr && obj_index == `DTP_IDX_CONTROL)
      probe_control_word <= obj_wdata[15:0];
  end

  // Selectors reach only the mailbox path; the stack picks the axis.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      probe1_capture_quantity_select <= `DTP_SELECT_RESET;
      probe2_capture_quantity_select <= `DTP_SELECT_RESET;
      probe1_internal_trigger_select <= `DTP_SELECT_RESET;
      probe2_internal_trigger_select <= `DTP_SELECT_RESET;
    end
    else if (wr)
    begin
      case (obj_index)
        `DTP_IDX_P1_QTY_SEL: probe1_capture_quantity_select <= obj_wdata[7:0];
        `DTP_IDX_P2_QTY_SEL: probe2_capture_quantity_select <= obj_wdata[7:0];
        `DTP_IDX_P1_INT_SEL: probe1_internal_trigger_select <= obj_wdata[7:0];
        `DTP_IDX_P2_INT_SEL: probe2_internal_trigger_select <= obj_wdata[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Probe channels
  // -------------------------------------------------------------
  // The timing pulse arrives already at one per 7.2 degrees.
  dtp_channel u_probe1
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ctl(dtp_ctl_half(probe_control_word[7:0])),
    .qty_command(probe1_capture_quantity_select[0]),
    .int_timing(probe1_internal_trigger_select[0]),
    .ext_latch(first_external_latch_input),
    .zero_marker(zero_marker_signal),
    .timing_pulse(rotation_timing_pulse),
    .feedback_pos(feedback_pos),
    .command_pos(command_pos),
    .rise_pos(p1_rise),
    .fall_pos(p1_fall),
    .status(sts1)
  );

  dtp_channel u_probe2
  (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .ctl(dtp_ctl_half(probe_control_word[15:8])),
    .qty_command(probe2_capture_quantity_select[0]),
    .int_timing(probe2_internal_trigger_select[0]),
    .ext_latch(second_external_latch_input),
    .zero_marker(zero_marker_signal),
    .timing_pulse(rotation_timing_pulse),
    .feedback_pos(feedback_pos),
    .command_pos(command_pos),
    .rise_pos(p2_rise),
    .fall_pos(p2_fall),
    .status(sts2)
  );

  assign probe_status_word = {sts2, sts1};

  // -------------------------------------------------------------
  // Transmit process data
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      transmit_process_data_status <= 16'h0000;
      transmit_process_data_p1_rise <= 32'sh0000_0000;
      transmit_process_data_p1_fall <= 32'sh0000_0000;
      transmit_process_data_p2_rise <= 32'sh0000_0000;
      transmit_process_data_p2_fall <= 32'sh0000_0000;
    end
    else
    begin
      transmit_process_data_status <= probe_status_word;
      transmit_process_data_p1_rise <= p1_rise;
      transmit_process_data_p1_fall <= p1_fall;
      transmit_process_data_p2_rise <= p2_rise;
      transmit_process_data_p2_fall <= p2_fall;
    end
  end

  // -------------------------------------------------------------
  // Object read path
  // -------------------------------------------------------------
  always_comb
  begin
    hit = 1'b1;
    next_rdata = 32'h0000_0000;
    case (obj_index)
      `DTP_IDX_P1_QTY_SEL: next_rdata[7:0] = probe1_capture_quantity_select;
      `DTP_IDX_P2_QTY_SEL: next_rdata[7:0] = probe2_capture_quantity_select;
      `DTP_IDX_P1_INT_SEL: next_rdata[7:0] = probe1_internal_trigger_select;
      `DTP_IDX_P2_INT_SEL: next_rdata[7:0] = probe2_internal_trigger_select;
      `DTP_IDX_CONTROL: next_rdata[15:0] = probe_control_word;
      `DTP_IDX_STATUS: next_rdata[15:0] = probe_status_word;
      `DTP_IDX_P1_RISE_POS: next_rdata = p1_rise;
      `DTP_IDX_P1_FALL_POS: next_rdata = p1_fall;
      `DTP_IDX_P2_RISE_POS: next_rdata = p2_rise;
      `DTP_IDX_P2_FALL_POS: next_rdata = p2_fall;
      default: hit = 1'b0;
    endcase
  end

  // Writes to read-only or unknown objects are refused with an error.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= 32'h0000_0000;
    end
    else
    begin
      obj_ack <= obj_req;
      obj_err <= obj_req &&
        (!hit || (obj_write && dtp_read_only(obj_index)));
      obj_rdata <= (obj_req && !obj_write && hit) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule // dtp_probe_latch

// File: hw/dtp_regs.svh
// Purpose: Register indices, field positions and reset values of the
//          dual touch probe position latch.
// Assumes: One axis per instance; the master selects the axis outside.
// Notes:   Object indices are kept as printed.
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

`define DTP_IDX_P1_QTY_SEL 16'h44B0
`define DTP_IDX_P2_QTY_SEL 16'h44B1
`define DTP_IDX_P1_INT_SEL 16'h44B2
`define DTP_IDX_P2_INT_SEL 16'h44B3
`define DTP_IDX_CONTROL 16'h60B8
`define DTP_IDX_STATUS 16'h60B9
`define DTP_IDX_P1_RISE_POS 16'h60BA
`define DTP_IDX_P1_FALL_POS 16'h60BB
`define DTP_IDX_P2_RISE_POS 16'h60BC
`define DTP_IDX_P2_FALL_POS 16'h60BD

// Field positions inside one 8-bit channel half.
`define DTP_CTL_ENABLE 0
`define DTP_CTL_CONTINUOUS 1
`define DTP_CTL_INTERNAL 2
`define DTP_CTL_RISE_EN 4
`define DTP_CTL_FALL_EN 5
`define DTP_STS_ENABLED 0
`define DTP_STS_RISE_DONE 1
`define DTP_STS_FALL_DONE 2
`define DTP_CH2_SHIFT 8

`define DTP_CONTROL_RESET 16'h0000
`define DTP_SELECT_RESET 8'h00

// Timing pulses per output-shaft revolution: 360 / 7.2.
`define DTP_TIMING_PULSES_PER_REV 50

`endif

// File: hw/dtp_pkg.sv
// Purpose: Types shared by the touch probe block.
// Assumes: Nothing beyond the register header.
// Notes:   Positions are signed step counts.
package dtp_pkg;
  typedef logic signed [31:0] dtp_pos_t;
  typedef logic [7:0] dtp_half_t;
  typedef enum logic [1:0]
  {
    DTP_IDLE = 2'b00,
    DTP_ARMED = 2'b01,
    DTP_DONE = 2'b10
  } dtp_arm_e;
endpackage

// File: hw/dtp_channel.sv
// Purpose: One probe channel: trigger select, edge detect, latch, flags.
// Assumes: Trigger inputs are synchronous to sys_clk.
// Notes:   Single mode disarms each polarity after its first capture.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_channel
  import dtp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire dtp_half_t ctl,
  input wire logic qty_command,
  input wire logic int_timing,
  input wire logic ext_latch,
  input wire logic zero_marker,
  input wire logic timing_pulse,
  input wire dtp_pos_t feedback_pos,
  input wire dtp_pos_t command_pos,
  output dtp_pos_t rise_pos,
  output dtp_pos_t fall_pos,
  output dtp_half_t status
);

  logic enabled;
  logic trig;
  logic trig_q;
  logic rise_done;
  logic fall_done;
  logic take_rise;
  logic take_fall;
  logic use_command;
  dtp_pos_t sample;

  assign enabled = ctl[`DTP_CTL_ENABLE];

  // -------------------------------------------------------------
  // Trigger source and captured quantity
  // -------------------------------------------------------------
  always_comb
  begin
    if (!ctl[`DTP_CTL_INTERNAL])
    begin
      trig = ext_latch;
      use_command = qty_command;
    end
    else
    begin
      trig = int_timing ? timing_pulse : zero_marker;
      use_command = int_timing;
    end
  end

  assign sample = use_command ? command_pos : feedback_pos;

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      trig_q <= 1'b0;
    else
      trig_q <= trig;
  end

  // -------------------------------------------------------------
  // Edge qualification
  // -------------------------------------------------------------
  // Disabled channel captures nothing; single mode stops after one.
  assign take_rise = enabled && ctl[`DTP_CTL_RISE_EN] && trig && !trig_q
    && (ctl[`DTP_CTL_CONTINUOUS] || !rise_done);
  assign take_fall = enabled && ctl[`DTP_CTL_FALL_EN] && !trig && trig_q
    && (ctl[`DTP_CTL_CONTINUOUS] || !fall_done);

  // -------------------------------------------------------------
  // Capture registers and flags
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rise_pos <= 32'sh0000_0000;
      fall_pos <= 32'sh0000_0000;
    end
    else
    begin
      if (take_rise)
        rise_pos <= sample;
      if (take_fall)
        fall_pos <= sample;
    end
  end

  // Flags clear while disabled, so re-enabling re-arms the channel.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rise_done <= 1'b0;
      fall_done <= 1'b0;
    end
    else if (!enabled)
    begin
      rise_done <= 1'b0;
      fall_done <= 1'b0;
    end
    else
    begin
      if (take_rise)
        rise_done <= 1'b1;
      if (take_fall)
        fall_done <= 1'b1;
    end
  end

  always_comb
  begin
    status = 8'h00;
    status[`DTP_STS_ENABLED] = enabled;
    // Flags are hidden in the cycle the enable drops, before they clear.
    status[`DTP_STS_RISE_DONE] = rise_done && enabled;
    status[`DTP_STS_FALL_DONE] = fall_done && enabled;
  end

endmodule // dtp_channel

// File: sim/dtp_probe_latch_asserts.sv
// Purpose: Port-level assertions for the probe latch.
// Assumes: Sees only the ports of dtp_probe_latch.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ps
module dtp_probe_latch_asserts
  import dtp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic receive_process_data_valid,
  input wire logic [15:0] receive_process_data_control,
  input wire logic [15:0] transmit_process_data_status,
  input wire dtp_pos_t transmit_process_data_p1_rise,
  input wire logic obj_req,
  input wire logic obj_write,
  input wire logic [15:0] obj_index,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [31:0] obj_rdata
);
  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire [15:0] st = transmit_process_data_status;
  a_ack_after_req:
    assert property (obj_req |=> obj_ack) else $error("ack missing");
  a_ack_has_cause:
    assert property (obj_ack |-> $past(obj_req)) else $error("stray ack");
  a_rdata_idle_zero:
    assert property (!obj_ack |-> obj_rdata == 32'h00000000)
    else $error("rdata not zero");
  a_ro_write_err:
    assert property (obj_req && obj_write &&
      obj_index inside {[16'h60B9:16'h60BD]} |=> obj_err)
    else $error("read-only write accepted");
  a_err_with_ack:
    assert property (obj_err |-> obj_ack) else $error("err without ack");
  a_status_reserved:
    assert property ((st & 16'hF8F8) == 16'h0000)
    else $error("reserved status bit set");
  a_flag1_needs_en:
    assert property (st[2:1] != 2'b00 |-> st[0]) else $error("flag1 stuck");
  a_flag2_needs_en:
    assert property (st[10:9] != 2'b00 |-> st[8]) else $error("flag2 stuck");
  a_enable_shown:
    assert property (receive_process_data_valid ##1
      !receive_process_data_valid [*3] |-> {st[8], st[0]} ==
      $past({receive_process_data_control[8],
      receive_process_data_control[0]}, 3))
    else $error("enable not reported");
  a_capture_flag:
    assert property ($changed(transmit_process_data_p1_rise) |-> st[1])
    else $error("capture without flag");
  c_err: cover property (obj_ack && obj_err);
  c_rise1: cover property ($rose(st[1]));
  c_fall1: cover property ($rose(st[2]));
  c_rise2: cover property ($rose(st[9]));
endmodule // dtp_probe_latch_asserts

bind dtp_probe_latch dtp_probe_latch_asserts i_asserts
(
  .sys_clk, .arst_n, .receive_process_data_valid,
  .receive_process_data_control, .transmit_process_data_status,
  .transmit_process_data_p1_rise, .obj_req, .obj_write, .obj_index,
  .obj_ack, .obj_err, .obj_rdata
);

// File: sim/dtp_master_model.sv
// Purpose: Fieldbus master: process data and mailbox object access.
// Assumes: The axis sub-index is decoded upstream.
// Notes:   Released lines show the inverse of their last value, except obj_write, which holds.
`timescale 1ns/1ps
module dtp_master_model
(
  input wire logic sys_clk,
  input wire logic obj_ack,
  input wire logic obj_err,
  input wire logic [31:0] obj_rdata,
  output logic pd_valid,
  output logic [15:0] pd_control,
  output logic obj_req,
  output logic obj_write,
  output logic [15:0] obj_index,
  output logic [31:0] obj_wdata
);
  initial
  begin
    pd_valid = 1'b0;
    pd_control = 16'h0000;
    obj_req = 1'b0;
    obj_write = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h00000000;
  end
  task automatic pdo(input logic [15:0] c);
    pd_valid = 1'b1;
    pd_control = c & 16'h3737;
    @(posedge sys_clk) #1;
    pd_valid = 1'b0;
    pd_control = ~pd_control;
  endtask
  task automatic obj(input logic w, input logic [15:0] idx,
    input logic [31:0] wd, output logic [31:0] rd, output logic er);
    obj_req = 1'b1;
    obj_write = w;
    obj_index = idx;
    obj_wdata = wd;
    @(posedge sys_clk) #1;
    obj_req = 1'b0;
    for (int i = 0; i < 4 && obj_ack !== 1'b1; i++)
      @(posedge sys_clk) #1;
    if (obj_ack !== 1'b1)
      dtp_probe_latch_test.timeout();
    else
    begin
      rd = obj_rdata;
      er = obj_err;
      obj_index = ~idx;
      obj_wdata = ~wd;
      @(posedge sys_clk) #1;
    end
  endtask
endmodule // dtp_master_model

// File: sim/dtp_probe_latch_test.sv
// Purpose: Self-checking test of the probe latch.
// Assumes: The master model owns process data and mailbox lines.
// Notes:   Triggers change 1 ns after a rising edge.
`timescale 1ns/1ps
`include "dtp_regs.svh"
module dtp_probe_latch_test
  import dtp_pkg::*;
;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic pd_valid, obj_req, obj_write, obj_ack, obj_err, er;
  logic [15:0] pd_control, obj_index, status;
  logic [31:0] obj_wdata, obj_rdata, rd;
  logic lat1 = 1'b0, lat2 = 1'b0, zm = 1'b0, tp = 1'b0;
  dtp_pos_t fb = 32'h00000064, cmd = 32'h000000C8, p1r, p1f, p2r, p2f;
  int errors = 0, n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  dtp_master_model i_master
  (
    .sys_clk(sys_clk), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_rdata(obj_rdata), .pd_valid(pd_valid), .pd_control(pd_control),
    .obj_req(obj_req), .obj_write(obj_write), .obj_index(obj_index),
    .obj_wdata(obj_wdata)
  );
  dtp_probe_latch i_dut
  (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .receive_process_data_valid(pd_valid),
    .receive_process_data_control(pd_control),
    .transmit_process_data_status(status),
    .transmit_process_data_p1_rise(p1r), .transmit_process_data_p1_fall(p1f),
    .transmit_process_data_p2_rise(p2r), .transmit_process_data_p2_fall(p2f),
    .obj_req(obj_req), .obj_write(obj_write), .obj_index(obj_index),
    .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_rdata(obj_rdata), .first_external_latch_input(lat1),
    .second_external_latch_input(lat2), .zero_marker_signal(zm),
    .rotation_timing_pulse(tp), .feedback_pos(fb), .command_pos(cmd)
  );
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic timeout();
    chk("obj_ack", 1'b0, 1'b1);
    report_and_stop();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk) #1;
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp,
    input logic eexp);
    i_master.obj(1'b0, idx, 32'h00000000, rd, er);
    chk("obj_err", er, eexp);
    if (!eexp)
      chk("obj_rdata", rd, exp);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
    input logic eexp);
    i_master.obj(1'b1, idx, d, rd, er);
    chk("obj_err", er, eexp);
  endtask
  task automatic pchk(input logic [15:0] st, input dtp_pos_t a, b, c, d);
    cyc(3);
    chk("status", status, st);
    chk("p1_rise", p1r, a);
    chk("p1_fall", p1f, b);
    chk("p2_rise", p2r, c);
    chk("p2_fall", p2f, d);
  endtask
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    cyc(8);
    arst_n = 1'b1;
    cyc(1);
    rdchk(`DTP_IDX_CONTROL, 32'h00000000, 1'b0);
    for (int i = 0; i < 4; i++)
      rdchk(16'(`DTP_IDX_P1_QTY_SEL + i), 32'h00000000, 1'b0);
    rdchk(`DTP_IDX_STATUS, 32'h00000000, 1'b0);
    rdchk(16'h1234, 32'h00000000, 1'b1);
    wr(`DTP_IDX_P1_RISE_POS, 32'h00000005, 1'b1);
    wr(`DTP_IDX_CONTROL, 32'h0000FFFF, 1'b0);
    rdchk(`DTP_IDX_CONTROL, 32'h0000FFFF, 1'b0);
    wr(`DTP_IDX_P1_QTY_SEL, 32'h00000001, 1'b0);
    rdchk(`DTP_IDX_P1_QTY_SEL, 32'h00000001, 1'b0);
    wr(`DTP_IDX_P2_INT_SEL, 32'h00000001, 1'b0);
    i_master.pdo(16'h1731);
    pchk(16'h0101, 0, 0, 0, 0);
    lat1 = 1'b1;
    pchk(16'h0103, 32'h000000C8, 0, 0, 0);
    zm = 1'b1;
    pchk(16'h0103, 32'h000000C8, 0, 0, 0);
    tp = 1'b1;
    pchk(16'h0303, 32'h000000C8, 0, 32'h000000C8, 0);
    cmd = 32'h0000012C;
    lat1 = 1'b0;
    pchk(16'h0307, 32'hC8, 32'h12C, 32'hC8, 0);
    lat1 = 1'b1;
    tp = 1'b0;
    pchk(16'h0307, 32'hC8, 32'h12C, 32'hC8, 0);
    tp = 1'b1;
    pchk(16'h0307, 32'hC8, 32'h12C, 32'h12C, 0);
    i_master.pdo(16'h1730);
    lat1 = 1'b0;
    pchk(16'h0300, 32'hC8, 32'h12C, 32'h12C, 0);
    i_master.pdo(16'h1731);
    lat1 = 1'b1;
    pchk(16'h0303, 32'h12C, 32'h12C, 32'h12C, 0);
    wr(`DTP_IDX_P2_QTY_SEL, 32'h00000001, 1'b0);
    wr(`DTP_IDX_P2_INT_SEL, 32'h00000000, 1'b0);
    zm = 1'b0;
    cyc(2);
    zm = 1'b1;
    pchk(16'h0303, 32'h12C, 32'h12C, 32'h64, 0);
    i_master.pdo(16'h3031);
    cyc(1);
    cmd = 32'h00000190;
    i_master.pdo(16'h3131);
    lat2 = 1'b1;
    pchk(16'h0303, 32'h12C, 32'h12C, 32'h190, 0);
    rdchk(`DTP_IDX_P2_RISE_POS, 32'h00000190, 1'b0);
    cmd = 32'h000001F4;
    lat2 = 1'b0;
    pchk(16'h0703, 32'h12C, 32'h12C, 32'h190, 32'h1F4);
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    pchk(16'h0000, 0, 0, 0, 0);
    rdchk(`DTP_IDX_CONTROL, 32'h00000000, 1'b0);
    report_and_stop();
  end
endmodule // dtp_probe_latch_test
